// ==== adis_defines.svh ====
// register offsets, field positions, reset values and channel codes for the input select and result formatter
`ifndef ADIS_DEFINES_SVH
`define ADIS_DEFINES_SVH
`define ADIS_CONTROL_ONE_INDEX 5'h00
`define ADIS_INPUT_SELECT_INDEX 5'h01
`define ADIS_BUFFER_BASE_INDEX 5'h02
`define ADIS_BUFFER_DEPTH 18
`define ADIS_CONTROL_ONE_RESET 16'h0000
`define ADIS_INPUT_SELECT_RESET 16'h0000
`define ADIS_ON_BIT 15
`define ADIS_TWELVE_BIT 10
`define ADIS_FORMAT_HI 9
`define ADIS_FORMAT_LO 8
`define ADIS_POS_REF_HI 14
`define ADIS_POS_REF_LO 13
`define ADIS_POS_UPPER_GUARD 5'h1c
`define ADIS_POS_LOWER_GUARD 5'h1b
`define ADIS_POS_BANDGAP 5'h1a
`define ADIS_POS_LAST_PIN 5'h15
`define ADIS_POS_FLOAT_FIRST 5'h16
`define ADIS_POS_FLOAT_LAST 5'h19
`define ADIS_POS_SUPPLY_LOW 5'h1d
`define ADIS_POS_SUPPLY_HIGH 5'h1e
`define ADIS_NODE_NONE 5'h1f
`define ADIS_NODE_REF_GROUND 5'h1e
`endif

// ==== adis_pkg.sv ====
// types shared by the input select and result formatter
package adis_pkg;
   typedef enum logic [1:0] {adis_integer, adis_signed_integer, adis_fractional, adis_signed_fractional} adis_format_type;
   typedef enum logic [2:0] {adis_src_none, adis_src_pin, adis_src_upper_guard, adis_src_lower_guard,
      adis_src_bandgap, adis_src_bandgap_scaled, adis_src_ref_ground} adis_source_type;
   typedef struct packed {
      adis_source_type source;
      logic [4:0] channel;
   } adis_route_type;
   typedef struct packed {
      logic valid;
      logic [4:0] slot;
      logic sign;
      logic [11:0] magnitude;
   } adis_result_type;
endpackage

// ==== adis_formatter.sv ====
// formats one conversion result into a 16-bit buffer word
`timescale 1ns/10ps
`include "adis_defines.svh"
module adis_formatter
   import adis_pkg::*;
(
   input wire logic i_twelve_bit,
   input wire adis_format_type i_format,
   input wire logic i_sign,
   input wire logic [11:0] i_magnitude,
   output logic [15:0] o_word
);
   logic [11:0] data;
   logic [15:0] signed_value;
   always_comb
   begin
      // 10-bit results sit in the low ten bits of the magnitude
      data = i_twelve_bit ? i_magnitude : {2'h0, i_magnitude[9:0]};
      // two's complement of the sign-and-offset code, sign extended
      signed_value = i_twelve_bit ? {{4{i_sign}}, data} : {{6{i_sign}}, data[9:0]};
      o_word = 16'h0000;
      case (i_format)
         adis_integer:
         begin
            // negative inputs clamp to zero in the unsigned forms
            o_word = i_sign ? 16'h0000 : {4'h0, data};
         end
         adis_signed_integer:
         begin
            o_word = signed_value;
         end
         adis_fractional:
         begin
            if (i_sign)
            begin
               o_word = 16'h0000;
            end
            else if (i_twelve_bit)
            begin
               o_word = {data, 4'h0};
            end
            else
            begin
               o_word = {data[9:0], 6'h00};
            end
         end
         adis_signed_fractional:
         begin
            if (i_twelve_bit)
            begin
               o_word = {i_sign, data, 3'h0};
            end
            else
            begin
               o_word = {i_sign, data[9:0], 5'h00};
            end
         end
         default:
         begin
            o_word = 16'h0000;
         end
      endcase
   end
endmodule // adis_formatter

// ==== adis_input_select.sv ====
// input routing, control registers and result buffer of the converter
`timescale 1ns/10ps
`include "adis_defines.svh"
//
// Function
// - sample B negative: ground, then AN0..AN6
// - upper guard, lower guard, band gap codes
// - low positive codes select matching pin
// - reference upper bit scales band gap
// - resolution bit ten picks 12/10 bits
// - unsigned magnitude 12 or 10 bits
// - signed forms add a sign bit
// - sign bit extends through upper bits
// - format field bits nine to eight
// - 12-bit signed integer: sign fills top
// - 12-bit fractional: bits 15:4, low zero
// - 12-bit signed fractional: sign 15, data 14:3
// - negative: unsigned zero, signed two's complement
// - positive full scale gives 4095
// - buffer writable only while converter off
// - on/off leaves buffer contents intact
module adis_input_select
   import adis_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [4:0] i_index,
   input wire logic [15:0] i_write_data,
   input wire logic i_sample_b,
   input wire adis_result_type i_result,
   output logic [15:0] o_read_data,
   output adis_route_type o_positive_route,
   output adis_route_type o_negative_route,
   output logic o_converter_on
);
   logic [15:0] converter_control_one;
   logic [15:0] sample_input_select;
   logic [15:0] conversion_result_buffer [`ADIS_BUFFER_DEPTH];
   logic [15:0] formatted;
   logic [15:0] next_read_data;
   logic [4:0] positive_code;
   logic [2:0] negative_code;
   logic buffer_hit;
   logic [4:0] buffer_slot;
   logic control_hit;
   logic select_hit;

   function automatic adis_route_type decode_positive(input logic [4:0] code, input logic scaled);
      adis_route_type route;
      route.source = adis_src_none;
      route.channel = `ADIS_NODE_NONE;
      if (code <= `ADIS_POS_LAST_PIN)
      begin
         route.source = adis_src_pin;
         route.channel = code;
      end
      else if (code == `ADIS_POS_UPPER_GUARD)
      begin
         route.source = adis_src_upper_guard;
         route.channel = code;
      end
      else if (code == `ADIS_POS_LOWER_GUARD)
      begin
         route.source = adis_src_lower_guard;
         route.channel = code;
      end
      else if (code == `ADIS_POS_BANDGAP)
      begin
         route.source = scaled ? adis_src_bandgap_scaled : adis_src_bandgap;
         route.channel = code;
      end
      // supply nodes are analog, reported on the reference side
      else if (code == `ADIS_POS_SUPPLY_HIGH)
      begin
         route.source = adis_src_ref_ground;
         route.channel = code;
      end
      else if (code == `ADIS_POS_SUPPLY_LOW)
      begin
         route.source = adis_src_ref_ground;
         route.channel = code;
      end
      // no-connect and unimplemented codes float the sampler input
      else if (code >= `ADIS_POS_FLOAT_FIRST && code <= `ADIS_POS_FLOAT_LAST)
      begin
         route.source = adis_src_none;
         route.channel = `ADIS_NODE_NONE;
      end
      return route;
   endfunction

   // both samples share one negative decoder; code zero is the converter ground
   function automatic adis_route_type decode_negative(input logic [2:0] code);
      adis_route_type route;
      route.source = adis_src_ref_ground;
      route.channel = `ADIS_NODE_REF_GROUND;
      if (code != 3'h0)
      begin
         route.source = adis_src_pin;
         route.channel = {2'h0, code - 3'h1};
      end
      return route;
   endfunction

   assign o_converter_on = converter_control_one[`ADIS_ON_BIT];
   assign positive_code = i_sample_b ? sample_input_select[12:8] : sample_input_select[4:0];
   assign negative_code = i_sample_b ? sample_input_select[15:13] : sample_input_select[7:5];
   assign buffer_slot = i_index - `ADIS_BUFFER_BASE_INDEX;
   assign buffer_hit = (i_index >= `ADIS_BUFFER_BASE_INDEX) && (buffer_slot < 5'(`ADIS_BUFFER_DEPTH));
   assign control_hit = (i_index == `ADIS_CONTROL_ONE_INDEX);
   assign select_hit = (i_index == `ADIS_INPUT_SELECT_INDEX);

   // on, resolution, format and reference scale all live in control one
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         converter_control_one <= `ADIS_CONTROL_ONE_RESET;
      end
      else if (i_write && control_hit)
      begin
         converter_control_one <= i_write_data;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         sample_input_select <= `ADIS_INPUT_SELECT_RESET;
      end
      else if (i_write && select_hit)
      begin
         sample_input_select <= i_write_data;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         o_positive_route <= '{source: adis_src_none, channel: `ADIS_NODE_NONE};
      end
      else
      begin
         o_positive_route <= decode_positive(positive_code, converter_control_one[`ADIS_POS_REF_HI]);
      end
   end

   // one register per route, each fed from its own decoder
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         o_negative_route <= '{source: adis_src_ref_ground, channel: `ADIS_NODE_REF_GROUND};
      end
      else
      begin
         o_negative_route <= decode_negative(negative_code);
      end
   end

   adis_formatter u_formatter
   (
      .i_twelve_bit(converter_control_one[`ADIS_TWELVE_BIT]),
      .i_format(adis_format_type'(converter_control_one[`ADIS_FORMAT_HI:`ADIS_FORMAT_LO])),
      .i_sign(i_result.sign),
      .i_magnitude(i_result.magnitude),
      .o_word(formatted)
   );

   // buffer has no reset so thresholds survive on/off; reset state is left as is
   always_ff @(posedge i_clock)
   begin
      if (o_converter_on)
      begin
         if (i_result.valid && i_result.slot < 5'(`ADIS_BUFFER_DEPTH))
         begin
            conversion_result_buffer[i_result.slot] <= formatted;
         end
      end
      else if (i_write && buffer_hit)
      begin
         conversion_result_buffer[buffer_slot] <= i_write_data;
      end
   end

   always_comb
   begin
      next_read_data = 16'h0000;
      if (control_hit)
      begin
         next_read_data = converter_control_one;
      end
      else if (select_hit)
      begin
         next_read_data = sample_input_select;
      end
      else if (buffer_hit)
      begin
         next_read_data = conversion_result_buffer[buffer_slot];
      end
   end

   // read word held between strobes so software may sample it late
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         o_read_data <= 16'h0000;
      end
      else if (i_read)
      begin
         o_read_data <= next_read_data;
      end
   end
endmodule // adis_input_select

// ==== adis_input_select_props.sv ====
// assertions on the routing and register ports of the input select
`timescale 1ns/10ps
module adis_input_select_props
   import adis_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [4:0] i_index,
   input wire logic [15:0] i_write_data,
   input wire logic i_sample_b,
   input wire adis_result_type i_result,
   input wire logic [15:0] o_read_data,
   input wire adis_route_type o_positive_route,
   input wire adis_route_type o_negative_route,
   input wire logic o_converter_on
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   // select write, then sample select held one more cycle
   sequence wa(c);
      i_write && i_index == 5'h01 && !i_sample_b && c ##1 !i_sample_b;
   endsequence
   sequence wb(c);
      i_write && i_index == 5'h01 && i_sample_b && c ##1 i_sample_b;
   endsequence
   upper_guard_a: assert property (wa(i_write_data[4:0] == 5'h1c) |=>
      o_positive_route.source == adis_src_upper_guard) else $error("upper guard route wrong");
   lower_guard_a: assert property (wa(i_write_data[4:0] == 5'h1b) |=>
      o_positive_route.source == adis_src_lower_guard) else $error("lower guard route wrong");
   pin_route_a: assert property (wa(i_write_data[4:0] <= 5'h15) |=> o_positive_route.source == adis_src_pin
      && o_positive_route.channel == $past(i_write_data[4:0], 2)) else $error("pin route wrong");
   unused_code_a: assert property (wa(i_write_data[4:0] == 5'h1f) |=>
      o_positive_route.source == adis_src_none) else $error("unused code routed");
   neg_ground_a: assert property (wb(i_write_data[15:13] == 3'h0) |=>
      o_negative_route.source == adis_src_ref_ground) else $error("ground route wrong");
   neg_pin_a: assert property (wb(i_write_data[15:13] != 3'h0) |=> o_negative_route.source == adis_src_pin
      && o_negative_route.channel == {2'h0, $past(i_write_data[15:13], 2)} - 5'h01) else $error("neg pin wrong");
   on_bit_a: assert property (i_write && i_index == 5'h00 |=>
      o_converter_on == $past(i_write_data[15])) else $error("on flag wrong");
   read_hold_a: assert property (!i_read |=> $stable(o_read_data)) else $error("read data moved");
endmodule // adis_input_select_props
bind adis_input_select adis_input_select_props i_props (.i_clock, .i_reset, .i_write, .i_read, .i_index,
   .i_write_data, .i_sample_b, .i_result, .o_read_data, .o_positive_route, .o_negative_route, .o_converter_on);

// ==== adis_conv_model.sv ====
// converter core stand-in that hands raw results to the block
`timescale 1ns/10ps
module adis_conv_model
   import adis_pkg::*;
(
   input wire logic i_clock,
   output adis_result_type o_result
);
   initial o_result = '0;
   task automatic convert(logic [4:0] slot, logic sign, logic [11:0] mag);
      @(posedge i_clock);
      #1;
      o_result = '{1'b1, slot, sign, mag};
      @(posedge i_clock);
      #1;
      // stale fields inverted so nothing leans on them
      o_result = '{1'b0, ~slot, ~sign, ~mag};
   endtask
endmodule // adis_conv_model

// ==== test_adis_input_select.sv ====
// self-checking bench for the input select and result formatter
`timescale 1ns/10ps
module test_adis_input_select;
   import adis_pkg::*;
   logic i_clock = 0, i_reset = 1, i_write = 0, i_read = 0, i_sample_b = 0;
   logic [4:0] i_index = 5'h00;
   logic [15:0] i_write_data = 16'h0000, o_read_data;
   adis_result_type i_result;
   adis_route_type o_positive_route, o_negative_route;
   logic o_converter_on;
   int errors = 0, n_checks = 0;
   // even entries on sample A, odd on sample B
   logic [4:0] pcode [8] = '{5'h00, 5'h15, 5'h1b, 5'h1a, 5'h1c, 5'h16, 5'h1f, 5'h1e};
   adis_source_type psrc [8] = '{adis_src_pin, adis_src_pin, adis_src_lower_guard, adis_src_bandgap,
      adis_src_upper_guard, adis_src_none, adis_src_none, adis_src_ref_ground};
   logic [15:0] fexp [16] = '{16'h0fff, 16'h0000, 16'h0fff, 16'hf000, 16'hfff0, 16'h0000, 16'h7ff8, 16'h8000,
      16'h03ff, 16'h0000, 16'h03ff, 16'hfe00, 16'hffc0, 16'h0000, 16'h7fe0, 16'hc000};
   adis_input_select i_dut (.i_clock, .i_reset, .i_write, .i_read, .i_index, .i_write_data, .i_sample_b,
      .i_result, .o_read_data, .o_positive_route, .o_negative_route, .o_converter_on);
   adis_conv_model i_conv (.i_clock, .o_result(i_result));
   always #4 i_clock = ~i_clock;
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(logic [4:0] idx, logic [15:0] d);
      @(posedge i_clock);
      #1;
      i_write = 1;
      i_index = idx;
      i_write_data = d;
      @(posedge i_clock);
      #1;
      i_write = 0;
   endtask
   task automatic rd(logic [4:0] idx, logic [15:0] exp, string name);
      @(posedge i_clock);
      #1;
      i_read = 1;
      i_index = idx;
      @(posedge i_clock);
      #1;
      i_read = 0;
      chk(name, exp, o_read_data);
   endtask
   // routes settle one cycle after the select register
   task automatic sel(logic [15:0] d, logic b);
      i_sample_b = b;
      wr(5'h01, d);
      @(posedge i_clock);
      #1;
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      errors++;
      conclude();
   end
   initial
   begin
      repeat (2) @(posedge i_clock);
      #1;
      i_reset = 0;
      chk("reset pos", 16'(adis_src_none), 16'(o_positive_route.source));
      chk("reset neg", 16'(adis_src_ref_ground), 16'(o_negative_route.source));
      rd(5'h00, 16'h0000, "control");
      rd(5'h01, 16'h0000, "select");
      rd(5'h1f, 16'h0000, "unmapped");
      for (int i = 0; i < 8; i++)
      begin
         sel(i[0] ? {3'h0, pcode[i], 8'h00} : {11'h000, pcode[i]}, i[0]);
         chk("pos source", 16'(psrc[i]), 16'(o_positive_route.source));
         if (i < 2)
            chk("pos channel", 16'(pcode[i]), 16'(o_positive_route.channel));
      end
      wr(5'h00, 16'h4000);
      sel(16'h001a, 1'b0);
      chk("scaled gap", 16'(adis_src_bandgap_scaled), 16'(o_positive_route.source));
      rd(5'h00, 16'h4000, "control back");
      rd(5'h01, 16'h001a, "select back");
      // first eight on sample B, last eight on sample A
      for (int n = 0; n < 16; n++)
      begin
         sel(n[3] ? {8'h00, n[2:0], 5'h00} : {n[2:0], 13'h0000}, !n[3]);
         chk("neg source", 16'(n[2:0] == 3'h0 ? adis_src_ref_ground : adis_src_pin),
            16'(o_negative_route.source));
         if (n[2:0] != 3'h0)
            chk("neg channel", 16'(n[2:0]) - 16'h0001, 16'(o_negative_route.channel));
      end
      for (int k = 0; k < 16; k++)
      begin
         wr(5'h00, {1'b1, 4'h0, ~k[3], k[2:1], 8'h00});
         i_conv.convert(5'(k), k[0], k[0] ? (k[3] ? 12'h200 : 12'h000) : (k[3] ? 12'h3ff : 12'hfff));
         rd(5'h02 + 5'(k), fexp[k], "word");
      end
      wr(5'h00, 16'h0000);
      wr(5'h13, 16'h1234);
      wr(5'h00, 16'h8000);
      wr(5'h13, 16'hbeef);
      rd(5'h13, 16'h1234, "threshold on");
      wr(5'h00, 16'h0000);
      chk("on flag", 16'h0000, 16'(o_converter_on));
      i_conv.convert(5'h11, 1'b0, 12'h555);
      rd(5'h13, 16'h1234, "threshold off");
      rd(5'h02, 16'h0fff, "kept word");
      conclude();
   end
endmodule // test_adis_input_select
